//--- shared/vpsd_pkg.sv
package vpsd_pkg;

  // ==========================================================
  // timebase
  // ==========================================================
  localparam int CLK_HZ        = 20_000_000;
  localparam int CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int PULSE_MAX_NS  = 30_000;                     // 30 us
  localparam int PULSE_CYC     = PULSE_MAX_NS / CLK_NS;      // longest time, rounded down
  localparam int PERIOD_MS     = 1600;                       // 1.6 s
  localparam int PERIOD_CYC    = PERIOD_MS * (CLK_HZ / 1000);
  localparam int PCNT_W        = 10;
  localparam int TCNT_W        = 25;

  // ==========================================================
  // register map
  // ==========================================================
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_PULSES  = 8'h08;
  localparam int          CTRL_VPOL   = 0;   // vsync active low
  localparam int          CTRL_RESTART = 1;  // write one to restart selection
  localparam int          ST_CHOSEN   = 0;
  localparam int          ST_PRES1    = 1;
  localparam int          ST_PRES2    = 2;
  localparam int          ST_AUTO     = 3;
  localparam int          ST_ENABLED  = 4;
  localparam int          ST_TEST     = 5;
  localparam int          ST_FSM_LSB  = 8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================
  // types
  // ==========================================================
  typedef enum logic [2:0] {
    S_OFF    = 3'h0,
    S_MODE   = 3'h1,
    S_PROBE  = 3'h2,
    S_CHOOSE = 3'h3,
    S_RUN    = 3'h4
  } vpsd_state_t;

  typedef struct packed {
    logic red;
    logic green;
    logic blue;
    logic hsync;
    logic vsync;
    logic ddc_data;
    logic ddc_clk;
  } vpsd_route_t;

  typedef struct packed {
    logic ce_n;
    logic mode;
    logic choice;
    logic vsync;
    logic sense1;
    logic sense2;
    logic test_n;
  } vpsd_pins_t;

  localparam vpsd_route_t ROUTE_OFF = 7'h00;
  localparam vpsd_route_t ROUTE_ALL = 7'h7F;
  localparam vpsd_pins_t  PINS_RST  = 7'h41;   // disabled, test high

  // port code: 0 is port one, 1 is port two
  function automatic logic choose_port(input logic auto_on, input logic prio,
                                       input logic p1, input logic p2);
    if (auto_on && (p1 ^ p2))
      return p2;
    return prio;
  endfunction : choose_port

endpackage : vpsd_pkg

//--- hdl/vpsd_sync.sv
`timescale 1ns/1ps
module vpsd_sync
  import vpsd_pkg::*;
(
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // pins in and clean levels out
  input  wire vpsd_pkg::vpsd_pins_t pins_raw,
  output      vpsd_pkg::vpsd_pins_t pins
);

  vpsd_pins_t s1;
  vpsd_pins_t s2;
  vpsd_pins_t s3;

  // ==========================================================
  // three stages; a bit moves only once stages two and three agree
  // ==========================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1   <= PINS_RST;
      s2   <= PINS_RST;
      s3   <= PINS_RST;
      pins <= PINS_RST;
    end
    else
    begin
      s1   <= pins_raw;
      s2   <= s1;
      s3   <= s2;
      pins <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & pins);
    end
  end

endmodule : vpsd_sync

//--- hdl/vpsd_probe_pulse.sv
`timescale 1ns/1ps
module vpsd_probe_pulse
  import vpsd_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // control
  input  wire logic start,
  input  wire logic abort,
  // pulse state
  output logic      active,
  output logic      done
);

  logic [PCNT_W-1:0] cnt;

  // ==========================================================
  // fixed width pulse; ends on its own well inside back porch
  // ==========================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn || abort)
    begin
      active <= 1'b0;
      cnt    <= '0;
    end
    else if (!active && start)
    begin
      active <= 1'b1;
      cnt    <= '0;
    end
    else if (active)
    begin
      active <= !done;
      cnt    <= cnt + PCNT_W'(1);
    end
  end

  // last cycle of the pulse, the sense comparators are sampled here
  assign done = active && (cnt == PCNT_W'(PULSE_CYC - 1));

endmodule : vpsd_probe_pulse

//--- hdl/vpsd_top.sv
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module vpsd_top #(
  parameter int unsigned PROBE_PERIOD_CYC = vpsd_pkg::PERIOD_CYC
) (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // control pins
  input  wire logic                 chip_enable_n,
  input  wire logic                 switch_mode_select,
  input  wire logic                 port_choice,
  input  wire logic                 test_mode_n,
  // source sync and termination sense per port
  input  wire logic                 vsync_source,
  input  wire logic                 term_sense_one,
  input  wire logic                 term_sense_two,
  // switch path enables
  output      vpsd_pkg::vpsd_route_t port_one_route,
  output      vpsd_pkg::vpsd_route_t port_two_route,
  // detection pulse drive on the blue lines
  output logic                      blue_port_one_probe,
  output logic                      blue_port_two_probe,
  // open drain monitor presence
  output logic                      hot_plug_indication_o,
  output logic                      hot_plug_indication_oe_n,
  // axi4-lite write address
  input  wire logic [7:0]           awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  // axi4-lite write data
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  // axi4-lite write response
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  // axi4-lite read address
  input  wire logic [7:0]           araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  // axi4-lite read data
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready
);
  import vpsd_pkg::*;

  // ==========================================================
  // declarations
  // ==========================================================
  vpsd_pins_t        pins_raw;
  vpsd_pins_t        pins;
  vpsd_state_t       state;
  logic              mode_seen;
  logic              auto_mode;
  logic              chosen;
  logic              pres1;
  logic              pres2;
  logic              chosen_pres;
  logic              vpol_low;
  logic              restart_req;
  logic              vs_d;
  logic              vs_active;
  logic              vs_trail;
  logic [TCNT_W-1:0] period_cnt;
  logic              period_hit;
  logic              start_pulse;
  logic              probe_active;
  logic              probe_done;
  logic              mode_changed;
  logic              loss;
  logic [31:0]       pulse_count;
  logic [31:0]       status_word;
  logic              wr_take;
  logic              rd_take;

  // ==========================================================
  // input conditioning
  // ==========================================================
  // pads carry pull-down on mode and pull-up on test, so open pins read as normal
  assign pins_raw = '{ce_n: chip_enable_n, mode: switch_mode_select, choice: port_choice,
                      vsync: vsync_source, sense1: term_sense_one, sense2: term_sense_two,
                      test_n: test_mode_n};

  vpsd_sync u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pins_raw (pins_raw),
    .pins     (pins)
  );

  // ==========================================================
  // event detection
  // ==========================================================
  // vsync polarity differs between video modes, software picks it
  assign vs_active    = pins.vsync ^ vpol_low;
  assign vs_trail     = vs_d && !vs_active;
  assign auto_mode    = !mode_seen;
  assign chosen_pres  = chosen ? pres2 : pres1;
  assign mode_changed = (state == S_PROBE || state == S_CHOOSE || state == S_RUN)
                        && (pins.mode != mode_seen);
  assign loss         = (state == S_RUN) && probe_done && chosen_pres
                        && !(chosen ? pins.sense2 : pins.sense1);
  assign period_hit   = period_cnt == TCNT_W'(PROBE_PERIOD_CYC - 1);

  // previous vsync level for the trailing edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      vs_d <= 1'b0;
    else
      vs_d <= vs_active;
  end

  // ==========================================================
  // port selection state machine
  // ==========================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= S_OFF;
    else if (pins.ce_n)
      state <= S_OFF;
    else
      unique case (state)
        S_OFF:    state <= S_MODE;
        S_MODE:   state <= S_PROBE;
        S_PROBE:
        begin
          if (mode_changed)
            state <= S_MODE;
          else if (probe_done)
            state <= S_CHOOSE;
        end
        S_CHOOSE: state <= mode_changed ? S_MODE : S_RUN;
        S_RUN:
        begin
          if (mode_changed || loss || restart_req)
            state <= S_MODE;
        end
        default:  state <= S_OFF;
      endcase
  end

  // mode is looked at once per selection round
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_seen <= 1'b0;
    else if (state == S_MODE)
      mode_seen <= pins.mode;
  end

  // ==========================================================
  // detection pulses
  // ==========================================================
  // in run a pulse starts at the vsync trailing edge, so it lands in back porch, or on the idle timer; selection starts one at once
  // a pulse that ended just as selection restarted is replaced, so probing never stalls
  assign start_pulse = !probe_active && ((state == S_MODE) || (state == S_PROBE)
                       || ((state == S_RUN) && (vs_trail || period_hit)));

  vpsd_probe_pulse u_pulse (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (start_pulse),
    .abort   (pins.ce_n),
    .active  (probe_active),
    .done    (probe_done)
  );

  // probes go out on both ports together, both driven by the one pulse
  assign blue_port_one_probe = probe_active;
  assign blue_port_two_probe = probe_active;

  // idle timer restarts on every pulse, so with live vsync it never fires
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state != S_RUN || start_pulse)
      period_cnt <= '0;
    else
      period_cnt <= period_cnt + TCNT_W'(1);
  end

  // per port presence, held until the next pulse ends
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state == S_OFF)
    begin
      pres1 <= 1'b0;
      pres2 <= 1'b0;
    end
    else if (probe_done)
    begin
      pres1 <= pins.sense1;
      pres2 <= pins.sense2;
    end
  end

  // ==========================================================
  // chosen port
  // ==========================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      chosen <= 1'b0;
    else if (state == S_CHOOSE)
      chosen <= choose_port(auto_mode, pins.choice, pres1, pres2);
    else if (state == S_RUN && !auto_mode)
      chosen <= pins.choice;
    else if (state == S_RUN && !chosen_pres)
      chosen <= choose_port(1'b1, pins.choice, pres1, pres2);
  end

  // ==========================================================
  // switch paths and presence pin
  // ==========================================================
  // paths only close after a choice; all seven move as one
  always_ff @(posedge aclk)
  begin
    if (!aresetn || pins.ce_n || state != S_RUN)
    begin
      port_one_route <= ROUTE_OFF;
      port_two_route <= ROUTE_OFF;
    end
    else
    begin
      port_one_route <= chosen ? ROUTE_OFF : ROUTE_ALL;
      port_two_route <= chosen ? ROUTE_ALL : ROUTE_OFF;
    end
  end

  // open drain: data fixed low, enable low only while driving
  assign hot_plug_indication_o = 1'b0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hot_plug_indication_oe_n <= 1'b1;
    else
      hot_plug_indication_oe_n <= !(state == S_RUN && !pins.ce_n && chosen_pres);
  end

  // ==========================================================
  // register slave
  // ==========================================================
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_PULSES);
  endfunction : is_mapped

  // address and data are taken together, one write outstanding at most
  assign wr_take = awvalid && wvalid && !bvalid;
  assign awready = wr_take;
  assign wready  = wr_take;
  assign rd_take = arvalid && !rvalid;
  assign arready = !rvalid;

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else if (wr_take)
    begin
      bvalid <= 1'b1;
      bresp  <= is_mapped({awaddr[7:2], 2'h0}) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // control register; restart bit is a one cycle strobe
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vpol_low    <= 1'b0;
      restart_req <= 1'b0;
    end
    else
    begin
      restart_req <= 1'b0;
      if (wr_take && {awaddr[7:2], 2'h0} == REG_CTRL && wstrb[0])
      begin
        vpol_low    <= wdata[CTRL_VPOL];
        restart_req <= wdata[CTRL_RESTART];
      end
    end
  end

  // count of detection pulses issued
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pulse_count <= 32'h0;
    else if (start_pulse)
      pulse_count <= pulse_count + 32'h1;
  end

  // live status snapshot; test pin shown for board checks
  always_comb
  begin
    status_word                     = 32'h0;
    status_word[ST_CHOSEN]          = chosen;
    status_word[ST_PRES1]           = pres1;
    status_word[ST_PRES2]           = pres2;
    status_word[ST_AUTO]            = auto_mode;
    status_word[ST_ENABLED]         = !pins.ce_n;
    status_word[ST_TEST]            = pins.test_n;
    status_word[ST_FSM_LSB +: 3]    = state;
  end

  // read data held until taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid <= 1'b1;
      rresp  <= is_mapped({araddr[7:2], 2'h0}) ? RESP_OKAY : RESP_SLVERR;
      unique case ({araddr[7:2], 2'h0})
        REG_CTRL:   rdata <= {30'h0, 1'b0, vpol_low};
        REG_STATUS: rdata <= status_word;
        REG_PULSES: rdata <= pulse_count;
        default:    rdata <= 32'h0;
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [PCNT_W:0] run_len;

  // helper: length of the current pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !probe_active)
      run_len <= '0;
    else
      run_len <= run_len + (PCNT_W + 1)'(1);
  end

  a_ce_hiz_paths: assert property (pins.ce_n |=> (port_one_route == ROUTE_OFF)
    && (port_two_route == ROUTE_OFF) && hot_plug_indication_oe_n)
    else $error("paths not released while disabled");
  a_mode_latch: assert property (state == S_MODE |=> auto_mode == !$past(pins.mode))
    else $error("mode not latched");
  a_manual_sel: assert property (state == S_RUN && !auto_mode
    |=> chosen == $past(pins.choice))
    else $error("manual choice not followed");
  a_one_monitor: assert property (state == S_CHOOSE && auto_mode && (pres1 ^ pres2)
    |=> chosen == $past(pres2))
    else $error("single monitor not chosen");
  a_both_prio: assert property (state == S_CHOOSE && auto_mode && pres1 && pres2
    |=> chosen == $past(pins.choice))
    else $error("priority ignored");
  a_hpi_drive: assert property (state == S_RUN && !pins.ce_n
    |=> hot_plug_indication_oe_n == !$past(chosen_pres))
    else $error("presence pin wrong");
  a_loss_restart: assert property (loss && !pins.ce_n |=> state == S_MODE ##1
    state == S_PROBE || pins.ce_n || mode_changed)
    else $error("no restart on loss");
  a_mode_restart: assert property (mode_changed && !pins.ce_n |=> state == S_MODE)
    else $error("no restart on mode change");
  a_ce_cycle: assert property (state == S_OFF && !pins.ce_n |=> state == S_MODE)
    else $error("no restart after enable");
  a_pulse_width: assert property (run_len <= (PCNT_W + 1)'(PULSE_CYC))
    else $error("probe pulse too long");
  a_vsync_probe: assert property (state == S_RUN && vs_trail && !probe_active
    && !pins.ce_n |=> probe_active)
    else $error("no probe after vsync");

  c_auto_both: cover property (state == S_CHOOSE && auto_mode && pres1 && pres2);
  c_loss: cover property (loss ##1 state == S_MODE);
  c_vsync_probe: cover property (state == S_RUN && vs_trail ##1 probe_active);
  c_manual_run: cover property (state == S_RUN && !auto_mode && chosen);

endmodule : vpsd_top

//--- testbench/vpsd_monitor_model.sv
`timescale 1ns/1ps
module vpsd_monitor_model (
  // probe drive from the switch
  input  wire logic blue_port_one_probe,
  input  wire logic blue_port_two_probe,
  // monitor plugged in per port
  input  wire logic attached_one,
  input  wire logic attached_two,
  // termination sense back to the switch
  output logic      term_sense_one,
  output logic      term_sense_two
);
  // ==========================================================
  // termination
  // ==========================================================
  // a load only shows while a pulse drives it, so no stale sense
  assign term_sense_one = blue_port_one_probe & attached_one;
  assign term_sense_two = blue_port_two_probe & attached_two;
endmodule : vpsd_monitor_model

//--- testbench/vpsd_top_bench.sv
`timescale 1ns/1ps
module vpsd_top_bench;
  import vpsd_pkg::*;
  // ==========================================================
  // signals
  // ==========================================================
  localparam int unsigned PERIOD = 2000;  // short idle repeat keeps the run brief
  localparam int          LIMIT  = 40000;
  logic        aclk = 1'b0, aresetn = 1'b0, chip_enable_n = 1'b0, switch_mode_select = 1'b0;
  logic        port_choice = 1'b0, test_mode_n = 1'b1, vsync_source = 1'b0;
  logic        attached_one = 1'b0, attached_two = 1'b1, term_sense_one, term_sense_two;
  vpsd_route_t port_one_route, port_two_route;
  logic        blue_port_one_probe, blue_port_two_probe;
  logic        hot_plug_indication_o, hot_plug_indication_oe_n;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] run_len = 32'h0, last_len = 32'h0;
  int          n_fail = 0, n_compared = 0, n_cycles = 0;

  vpsd_top #(.PROBE_PERIOD_CYC(PERIOD)) dut_u (
    .aclk, .aresetn, .chip_enable_n, .switch_mode_select, .port_choice, .test_mode_n,
    .vsync_source, .term_sense_one, .term_sense_two, .port_one_route, .port_two_route,
    .blue_port_one_probe, .blue_port_two_probe, .hot_plug_indication_o,
    .hot_plug_indication_oe_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready);

  vpsd_monitor_model mon_u (.blue_port_one_probe, .blue_port_two_probe, .attached_one,
    .attached_two, .term_sense_one, .term_sense_two);

  // ==========================================================
  // clock, pulse width, timeout
  // ==========================================================
  always #25 aclk = ~aclk;

  // length of the last finished pulse on port one
  always @(posedge aclk)
  begin
    if (blue_port_one_probe)
      run_len <= run_len + 1;
    else if (run_len != 0)
    begin
      last_len <= run_len;
      run_len  <= 32'h0;
    end
  end

  // a hang counts as a mismatch
  always @(posedge aclk)
  begin
    n_cycles <= n_cycles + 1;
    if (n_cycles == LIMIT)
    begin
      n_fail++;
      results();
    end
  end

  // ==========================================================
  // helpers
  // ==========================================================
  task automatic results();
    if (n_fail == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [14:0] st();
    return {port_one_route, port_two_route, hot_plug_indication_oe_n};
  endfunction : st

  // bounded wait for the paths and presence output to settle
  task automatic wait_for(input logic [14:0] e);
    for (int i = 0; i < 5000 && st() !== e; i++)
      @(posedge aclk);
  endtask : wait_for

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    @(posedge aclk);
    while (!(awready && wready))
      @(posedge aclk);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b1;
    @(posedge aclk);
    while (!bvalid)
      @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    @(posedge aclk);
    while (!arready)
      @(posedge aclk);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    @(posedge aclk);
    while (!rvalid)
      @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_single();
    @(posedge aclk);
    check(st(), {ROUTE_OFF, ROUTE_OFF, 1'b1});
    wait_for({ROUTE_OFF, ROUTE_ALL, 1'b0});
    check(st(), {ROUTE_OFF, ROUTE_ALL, 1'b0});
    check({hot_plug_indication_o, port_two_route}, {1'b0, ROUTE_ALL});
    check(last_len, PULSE_CYC);
  endtask : t_single

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(REG_STATUS, d, r);
    check({r, d[10:8], d[5:0]}, {RESP_OKAY, 3'h4, 6'h3D});
    axi_read(8'h0C, d, r);
    check(r, RESP_SLVERR);
    check(d, 32'h0);
    axi_write(8'h0C, 32'h1, r);
    check(r, RESP_SLVERR);
    axi_write(REG_CTRL, 32'h1, r);
    axi_read(REG_CTRL, d, r);
    check(d[1:0], 2'h1);
    axi_read(REG_PULSES, d, r);
    check(d, 32'h1);
    axi_write(REG_CTRL, 32'h0, r);
  endtask : t_regs

  task automatic t_both();
    logic [14:0] e;
    logic [1:0]  r;
    attached_one <= 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      port_choice <= p[0];
      e = p[0] ? {ROUTE_OFF, ROUTE_ALL, 1'b0} : {ROUTE_ALL, ROUTE_OFF, 1'b0};
      axi_write(REG_CTRL, 32'h2, r);  // restart selection
      wait_for(e);
      check(st(), e);
    end
  endtask : t_both

  task automatic t_none_manual();
    attached_one <= 1'b0;
    attached_two <= 1'b0;
    port_choice  <= 1'b0;
    wait_for({ROUTE_ALL, ROUTE_OFF, 1'b1});
    check(st(), {ROUTE_ALL, ROUTE_OFF, 1'b1});
    attached_two       <= 1'b1;
    switch_mode_select <= 1'b1;
    port_choice        <= 1'b1;
    wait_for({ROUTE_OFF, ROUTE_ALL, 1'b0});
    check(st(), {ROUTE_OFF, ROUTE_ALL, 1'b0});
    port_choice <= 1'b0;
    wait_for({ROUTE_ALL, ROUTE_OFF, 1'b1});
    check(st(), {ROUTE_ALL, ROUTE_OFF, 1'b1});
  endtask : t_none_manual

  task automatic t_vsync_enable();
    int i;
    for (i = 0; i < 700 && blue_port_one_probe; i++)
      @(posedge aclk);
    vsync_source <= 1'b1;
    repeat (10) @(posedge aclk);
    vsync_source <= 1'b0;
    for (i = 0; i < 20 && !blue_port_one_probe; i++)
      @(posedge aclk);
    check(i <= 8, 1'b1);
    check(blue_port_two_probe, 1'b1);
    chip_enable_n <= 1'b1;
    repeat (8) @(posedge aclk);
    check({st(), blue_port_one_probe}, {ROUTE_OFF, ROUTE_OFF, 2'h2});
    check(blue_port_two_probe, 1'b0);
    chip_enable_n <= 1'b0;
    wait_for({ROUTE_ALL, ROUTE_OFF, 1'b1});
    check(st(), {ROUTE_ALL, ROUTE_OFF, 1'b1});
  endtask : t_vsync_enable

  // ==========================================================
  // main sequence
  // ==========================================================
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_single();
    t_regs();
    t_both();
    t_none_manual();
    t_vsync_enable();
    results();
  end
endmodule : vpsd_top_bench
